// ### hw/acs_adc_control_sequencer.sv
// converter control sequencer: apb register file, continuous conversion control
// assumes an external sar core that presents its result when done is pulsed
//
// Overview of operation
// (R1) input above high reference reports all ones, no overflow flag
// (R2) input below low reference reports zero in both result registers
// (R3) setting converter_on starts continuous repeated conversions of the channel
// (R4) each completed conversion stores result and sets end-of-conversion flag
// (R5) reading result_high_byte or writing control/status clears the flag
// (R6) every new result overwrites both result registers, read or not
// (R7) software reads low then high before next conversion ends
// (R8) software wanting eight bits reads only result_high_byte
// (R9) channel change aborts conversion, clears flag, restarts on new channel
// (R10) speed bit selects cpu clock divided by four or by two
// (R11) clearing converter_on stops any conversion in progress
// (R12) software writes zero to the reserved bit
// (R13) four-bit channel_select picks analog input zero to fifteen
// (R14) high register holds bits 9:2, low register bits 1:0, rest zero
// (R15) wait mode leaves the converter running unchanged
// (R16) halt disables converter; settling interval follows wake-up
// (R17) all three registers reset to zero
// (R18) flag is read-only; other control bits read and write
// (R19) no interrupt request; completion only via polled flag
// (R20) conversion length in converter clock cycles is a parameter
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module acs_adc_control_sequencer #(
  parameter int CONV_CYC = acs_pkg::ACS_CONV_ADC_CYC,
  parameter int STAB_CYC = acs_pkg::ACS_STAB_CYC
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // low-power mode levels from the clock controller
  input wire logic halt_in,
  input wire logic wait_in,
  // sar core
  input wire logic [9:0] sar_data_in,
  input wire logic sar_above_in,
  input wire logic sar_below_in,
  output logic [3:0] channel_select_out,
  output logic converter_on_out,
  output logic sar_start_out,
  output logic sar_step_out
);
  import acs_pkg::*;

  // ************************************************************
  // elaboration checks
  // ************************************************************
  if (CONV_CYC < 1 || CONV_CYC > 255) begin : g_bad_conv
    $error("conversion length out of range");
  end
  if (STAB_CYC < 1 || STAB_CYC > 65535) begin : g_bad_stab
    $error("settling length out of range");
  end

  localparam logic [7:0] CONV_LAST = 8'(CONV_CYC - 1);
  localparam logic [15:0] STAB_LAST = 16'(STAB_CYC - 1);

  // ************************************************************
  // apb decode
  // ************************************************************
  logic apb_acc;
  logic wr_csr;
  logic rd_high;
  logic hit_csr;
  logic hit_high;
  logic hit_low;
  logic mapped;
  assign hit_csr = paddr_in == ACS_CSR_OFF;
  assign hit_high = paddr_in == ACS_RES_HIGH_OFF;
  assign hit_low = paddr_in == ACS_RES_LOW_OFF;
  assign mapped = hit_csr || hit_high || hit_low;
  // single-cycle access phase: every access completes when penable is seen
  assign apb_acc = psel_in && penable_in;
  assign wr_csr = apb_acc && pwrite_in && hit_csr;
  assign rd_high = apb_acc && !pwrite_in && hit_high;

  // ************************************************************
  // synchronise low-power levels
  // ************************************************************
  logic halt_s1_q;
  logic halt_s2_q;
  logic wait_s1_q;
  logic wait_s2_q;
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      halt_s1_q <= 1'b0;
      halt_s2_q <= 1'b0;
      wait_s1_q <= 1'b0;
      wait_s2_q <= 1'b0;
    end else begin
      halt_s1_q <= halt_in;
      halt_s2_q <= halt_s1_q;
      wait_s1_q <= wait_in;
      wait_s2_q <= wait_s1_q;
    end
  end
  // wait is observed but deliberately steers nothing
  logic wait_seen;
  assign wait_seen = wait_s2_q; // R15

  // ************************************************************
  // control/status register
  // ************************************************************
  logic speed_q;
  logic on_q;
  logic [3:0] ch_q;
  logic eoc_q;
  logic eoc_d;
  logic ch_change;
  logic conv_done;
  logic [3:0] wr_ch;
  assign wr_ch = pwdata_in[ACS_CH_LSB +: ACS_CH_W];
  assign ch_change = wr_csr && (wr_ch != ch_q); // R9
  // set wins over a clear in the same cycle, except a channel change,
  // which clears the flag although the result is still stored
  assign eoc_d = (conv_done && !ch_change) ? 1'b1
               : (wr_csr || rd_high) ? 1'b0 // R5
               : eoc_q;

  // writable bits; flag and reserved bit ignore writes
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      speed_q <= ACS_CSR_RST[ACS_SPEED_BIT]; // R17
      on_q <= ACS_CSR_RST[ACS_ON_BIT];
      ch_q <= ACS_CSR_RST[ACS_CH_W-1:0];
      eoc_q <= ACS_CSR_RST[ACS_EOC_BIT];
    end else begin
      if (wr_csr) begin
        speed_q <= pwdata_in[ACS_SPEED_BIT]; // R10 R18
        on_q <= pwdata_in[ACS_ON_BIT]; // R3 R11
        ch_q <= wr_ch; // R13
      end
      eoc_q <= eoc_d; // R18
    end
  end

  // ************************************************************
  // converter clock and sequencer
  // ************************************************************
  logic run;
  logic adc_tick;
  acs_state_t state_q;
  acs_state_t state_d;
  logic [7:0] step_q;
  logic [7:0] step_d;
  logic [15:0] stab_q;
  logic [15:0] stab_d;
  logic halted_q;
  // halt forces the converter off regardless of the on bit
  assign run = on_q && !halt_s2_q; // R16

  acs_clk_div u_div (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .run_in(run && state_q == ACS_CONVERT),
    .fast_in(speed_q),
    .tick_out(adc_tick)
  );

  // remembers that halt was seen so the next start settles first
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      halted_q <= 1'b0;
    end else if (halt_s2_q) begin
      halted_q <= 1'b1;
    end else if (state_q == ACS_SETTLE && stab_q == STAB_LAST) begin
      halted_q <= 1'b0;
    end
  end

  assign conv_done = state_q == ACS_CONVERT && adc_tick && step_q == CONV_LAST; // R4 R20

  // next state; off, halt or channel change all pull back to idle
  always_comb begin
    state_d = state_q;
    step_d = step_q;
    stab_d = stab_q;
    case (state_q)
      ACS_IDLE: begin
        step_d = 8'h00;
        stab_d = 16'h0000;
        if (run && !ch_change) begin
          state_d = halted_q ? ACS_SETTLE : ACS_CONVERT; // R3
        end
      end
      ACS_SETTLE: begin
        stab_d = stab_q + 16'h0001;
        if (stab_q == STAB_LAST) begin
          state_d = ACS_CONVERT; // R16
        end
      end
      ACS_CONVERT: begin
        if (adc_tick) begin
          // back to back conversions: wrap counter and carry on
          step_d = (step_q == CONV_LAST) ? 8'h00 : step_q + 8'h01; // R3
        end
      end
      default: begin
        state_d = ACS_IDLE;
      end
    endcase
    if (!run || ch_change) begin
      state_d = ACS_IDLE; // R9 R11
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      state_q <= ACS_IDLE;
      step_q <= 8'h00;
      stab_q <= 16'h0000;
    end else begin
      state_q <= state_d;
      step_q <= step_d;
      stab_q <= stab_d;
    end
  end

  // ************************************************************
  // result capture
  // ************************************************************
  logic [9:0] res_q;
  logic [9:0] res_d;
  // out-of-range inputs clamp; no overflow bit exists
  assign res_d = sar_above_in ? ACS_FULL_SCALE // R1
               : sar_below_in ? ACS_ZERO_SCALE // R2
               : sar_data_in;
  // no latching against overwrite: every completion replaces both halves
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      res_q <= {ACS_RES_RST[1:0], ACS_RES_RST}; // R17
    end else if (conv_done) begin
      res_q <= res_d; // R6
    end
  end

  // ************************************************************
  // read mux
  // ************************************************************
  logic [7:0] csr_view;
  logic [7:0] rd_byte;
  assign csr_view = {eoc_q, speed_q, on_q, 1'b0, ch_q};
  assign rd_byte = hit_csr ? csr_view
                 : hit_high ? res_q[9:2] // R14
                 : hit_low ? {6'b000000, res_q[1:0]} // R14
                 : 8'h00;

  // ************************************************************
  // registered outputs
  // ************************************************************
  // pready is registered from the setup cycle so it is high in the access cycle, which lasts one cycle
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      prdata_out <= 32'h0000_0000;
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      channel_select_out <= 4'h0;
      converter_on_out <= 1'b0;
      sar_start_out <= 1'b0;
      sar_step_out <= 1'b0;
    end else begin
      pready_out <= psel_in && !penable_in;
      pslverr_out <= psel_in && !penable_in && !mapped;
      prdata_out <= (psel_in && !penable_in && !pwrite_in) ? {24'h000000, rd_byte} : 32'h0000_0000;
      channel_select_out <= ch_q; // R13
      converter_on_out <= run; // R11 R16
      sar_start_out <= (state_d == ACS_CONVERT) && (state_q != ACS_CONVERT || conv_done);
      // gated by run so no step trails a switch-off or a halt
      sar_step_out <= adc_tick && state_q == ACS_CONVERT && run; // R11 R16
    end
  end
  // no interrupt output exists; completion is only the polled flag  (R19)
  logic unused_ok;
  assign unused_ok = wait_seen ^ pwdata_in[ACS_RSVD_BIT];
endmodule
`default_nettype wire

// ### shared/acs_pkg.sv
// package for the converter control sequencer: offsets, fields, reset values, timing
// assumes a 32-bit apb slave with one register per aligned word
package acs_pkg;
  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [11:0] ACS_CSR_OFF = 12'h000;
  localparam logic [11:0] ACS_RES_HIGH_OFF = 12'h004;
  localparam logic [11:0] ACS_RES_LOW_OFF = 12'h008;
  // ************************************************************
  // control/status field positions
  // ************************************************************
  localparam int ACS_EOC_BIT = 7;
  localparam int ACS_SPEED_BIT = 6;
  localparam int ACS_ON_BIT = 5;
  localparam int ACS_RSVD_BIT = 4;
  localparam int ACS_CH_LSB = 0;
  localparam int ACS_CH_W = 4;
  // ************************************************************
  // reset values and result codes
  // ************************************************************
  localparam logic [7:0] ACS_CSR_RST = 8'h00;
  localparam logic [7:0] ACS_RES_RST = 8'h00;
  localparam logic [9:0] ACS_FULL_SCALE = 10'h3FF;
  localparam logic [9:0] ACS_ZERO_SCALE = 10'h000;
  // ************************************************************
  // timing
  // ************************************************************
  localparam int ACS_CLK_MHZ = 100;
  localparam int ACS_STAB_US = 1;
  localparam int ACS_STAB_CYC = ACS_STAB_US * ACS_CLK_MHZ;
  localparam int ACS_CONV_ADC_CYC = 14;
  // converter sequencer states
  typedef enum logic [1:0] {
    ACS_IDLE = 2'b00,
    ACS_SETTLE = 2'b01,
    ACS_CONVERT = 2'b10
  } acs_state_t;
endpackage

// ### hw/acs_clk_div.sv
// converter clock tick generator: divide-by-2 or divide-by-4 of the cpu clock
// assumes speed select is a level from the same clock domain
`timescale 1ns/10ps
`default_nettype none
module acs_clk_div (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic run_in,
  input wire logic fast_in,
  output logic tick_out
);
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  logic wrap;
  // fast wraps at 1 (div 2), slow at 3 (div 4)
  assign wrap = fast_in ? cnt_q[0] : (cnt_q == 2'b11);
  assign cnt_d = (!run_in || wrap) ? 2'b00 : cnt_q + 2'b01;
  // counter restarts whenever the converter stops so each run starts aligned
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      cnt_q <= 2'b00;
      tick_out <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_out <= run_in && wrap;
    end
  end
endmodule
`default_nettype wire

// ### sim/acs_sar_model.sv
// sar core stand-in: returns channel and bench sample, clamp flags from bench
// assumes the sequencer core side, one clock
`timescale 1ns/10ps
`default_nettype none
module acs_sar_model (
  input wire logic [3:0] chan_in,
  input wire logic on_in,
  input wire logic [5:0] samp_in,
  input wire logic hi_in,
  input wire logic lo_in,
  output logic [9:0] data_out,
  output logic above_out,
  output logic below_out
);
  // a powered-down core shows junk, never a stale result
  assign data_out = on_in ? {chan_in, samp_in} : ~{chan_in, samp_in};
  assign above_out = hi_in & on_in;
  assign below_out = lo_in & on_in;
endmodule
`default_nettype wire

// ### sim/acs_checker.sv
// port checker: apb timing, register shape, converter gating
// assumes one clock, synchronous active-high reset
`timescale 1ns/10ps
`default_nettype none
module acs_checker (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic halt_in,
  input wire logic converter_on_out,
  input wire logic sar_step_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  chk_rdy_setup: assert property (psel_in && !penable_in |=> pready_out)
    else $error("no ready in access cycle");
  chk_rdy_pulse: assert property (pready_out |=> !pready_out)
    else $error("ready longer than one cycle");
  chk_unmapped_err: assert property (psel_in && !penable_in && paddr_in > 12'h008
    |=> pslverr_out && prdata_out == 32'h0) else $error("unmapped not refused");
  chk_upper_zero: assert property (pready_out |-> prdata_out[31:8] == 24'h0)
    else $error("upper read bits set");
  chk_low_shape: assert property (pready_out && !pwrite_in && paddr_in == 12'h008
    |-> prdata_out[7:2] == 6'h0) else $error("low result upper bits set");
  chk_rsvd_zero: assert property (pready_out && !pwrite_in && paddr_in == 12'h000
    |-> !prdata_out[4]) else $error("reserved bit reads one");
  chk_halt_off: assert property (halt_in [*4] |-> !converter_on_out)
    else $error("converter on during halt");
  chk_step_gap: assert property (sar_step_out |=> !sar_step_out)
    else $error("converter clock faster than half");
  chk_step_on: assert property (sar_step_out |-> converter_on_out)
    else $error("step while converter off");
endmodule
bind acs_adc_control_sequencer acs_checker acs_checker_inst (.mclk_in, .rst_in, .psel_in,
  .penable_in, .pwrite_in, .paddr_in, .prdata_out, .pready_out, .pslverr_out, .halt_in,
  .converter_on_out, .sar_step_out);
`default_nettype wire

// ### sim/acs_adc_control_sequencer_tb.sv
// bench for the sequencer: apb master, sar stand-in, random samples
// assumes the checker is bound; short conversion and settle counts
`timescale 1ns/10ps
`default_nettype none
module acs_adc_control_sequencer_tb;
  import acs_pkg::*;
  logic mclk_in = 0, rst_in = 1, psel = 0, penable = 0, pwrite = 0;
  logic halt = 0, waitm = 0, hi = 0, lo = 0, err, pready, pslverr, on, start, step, sab, sbe;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h14;
  logic [5:0] samp = 6'h00;
  logic [3:0] chan, c;
  logic [9:0] sdata, e;
  int mismatches = 0, n_checks = 0, cyc = 0, sg = 0;
  always #5 mclk_in = ~mclk_in;
  acs_adc_control_sequencer #(.CONV_CYC(6), .STAB_CYC(4)) acs_adc_control_sequencer_inst (
    .mclk_in(mclk_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .halt_in(halt), .wait_in(waitm),
    .sar_data_in(sdata), .sar_above_in(sab), .sar_below_in(sbe), .channel_select_out(chan),
    .converter_on_out(on), .sar_start_out(start), .sar_step_out(step));
  acs_sar_model acs_sar_model_inst (.chan_in(chan), .on_in(on), .samp_in(samp), .hi_in(hi),
    .lo_in(lo), .data_out(sdata), .above_out(sab), .below_out(sbe));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // clamps win over the sampled code
  function automatic logic [9:0] code(input logic [3:0] ch, input logic [5:0] s);
    return hi ? ACS_FULL_SCALE : (lo ? ACS_ZERO_SCALE : {ch, s});
  endfunction
  task automatic end_of_test();
    if (mismatches == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // one transfer; entered just after an edge, ends one idle cycle later
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_in);
    penable <= 1'b1;
    do begin
      @(posedge mclk_in);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    if (n >= 20) begin
      mismatches++;
      $display("MISMATCH at %0t: no ready from slave", $time);
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk_in);
  endtask
  task automatic wait_eoc();
    int k;
    k = 0;
    do begin
      apb(0, ACS_CSR_OFF, 0);
      k++;
    end while (rd[7] !== 1'b1 && k < 40);
    chk({31'h0, rd[7]}, 1);
  endtask
  // converter clock period from the first step of a fresh conversion
  task automatic step_gap(input int want);
    int g;
    g = 0;
    while (start !== 1'b1 && g < 99) begin
      @(posedge mclk_in);
      g++;
    end
    while (step !== 1'b1 && g < 99) begin
      @(posedge mclk_in);
      g++;
    end
    g = 0;
    do begin
      @(posedge mclk_in);
      g++;
    end while (step !== 1'b1 && g < 50);
    chk(g, want);
  endtask
  // ****************
  // hang guard
  // ****************
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 6000) begin
      mismatches++;
      $display("MISMATCH at %0t: run timed out", $time);
      end_of_test();
    end
  end
  initial begin
    repeat (5) @(posedge mclk_in);
    rst_in <= 1'b0;
    @(posedge mclk_in);
    apb(0, ACS_CSR_OFF, 0);
    chk(rd, ACS_CSR_RST);
    apb(0, ACS_RES_HIGH_OFF, 0);
    chk(rd, ACS_RES_RST);
    apb(0, ACS_RES_LOW_OFF, 0);
    chk(rd, ACS_RES_RST);
    apb(0, 12'h00C, 0);
    chk({31'h0, err}, 1);
    chk(rd, 0);
    // flag written high must be ignored; reserved bit kept clear
    apb(1, ACS_CSR_OFF, 32'hE0);
    apb(0, ACS_CSR_OFF, 0);
    chk(rd, 32'h60);
    step_gap(2);
    apb(1, ACS_CSR_OFF, 32'h20);
    step_gap(4);
    for (int i = 0; i < 16; i++) begin
      seed = xs(seed);
      c = 4'(i) ^ 4'h5;
      samp <= seed[5:0];
      waitm <= seed[6];
      hi <= (i == 3);
      lo <= (i == 5);
      apb(1, ACS_CSR_OFF, 32'h20 | 32'(c));
      apb(0, ACS_CSR_OFF, 0);
      chk(rd, 32'h20 | 32'(c));
      wait_eoc();
      e = code(c, samp);
      apb(0, ACS_RES_LOW_OFF, 0);
      chk(rd, {30'h0, e[1:0]});
      apb(0, ACS_RES_HIGH_OFF, 0);
      chk(rd, {24'h0, e[9:2]});
      apb(0, ACS_CSR_OFF, 0);
      chk({31'h0, rd[7]}, 0);
    end
    hi <= 1'b0;
    lo <= 1'b0;
    // eight-bit reader: poll, then the high byte alone
    wait_eoc();
    e = code(c, samp);
    apb(0, ACS_RES_HIGH_OFF, 0);
    chk(rd, {24'h0, e[9:2]});
    wait_eoc();
    apb(1, ACS_CSR_OFF, 32'h20 | 32'(c));
    apb(0, ACS_CSR_OFF, 0);
    chk({31'h0, rd[7]}, 0);
    halt <= 1'b1;
    repeat (6) @(posedge mclk_in);
    chk({31'h0, on}, 0);
    halt <= 1'b0;
    // after wake-up the first start must trail converter_on by the settle count
    while (on !== 1'b1 && sg < 50) begin
      @(posedge mclk_in);
      sg++;
    end
    sg = 0;
    while (start !== 1'b1 && sg < 50) begin
      @(posedge mclk_in);
      sg++;
    end
    chk(sg, 4);
    wait_eoc();
    apb(1, ACS_CSR_OFF, 0);
    repeat (60) @(posedge mclk_in);
    chk({31'h0, on}, 0);
    apb(0, ACS_CSR_OFF, 0);
    chk(rd, 0);
    end_of_test();
  end
endmodule
`default_nettype wire
